// [fap_pkg.sv]
// How it works
// RQ1 - id mode returns codes on data_low_byte, not array data
// RQ2 - elevated method: A6 low, A1/A0 pick the id item
// RQ3 - elevated id only while id_voltage_address_line is asserted
// RQ4 - sector on top address bits; 01h protected, 00h unprotected
// RQ5 - id also reachable in-system by the autoselect command sequence
// RQ6 - protected sectors refuse program and erase
// RQ7 - host protects every sector before the first unprotect write cycle; host instead refuses unprotect until its prot record is all ones
// RQ8 - every sector leaves the factory unprotected
// RQ9 - program needs the unlock cycles; lone writes never change the array
// RQ10 - control pulses under 5ns never start a write cycle
// RQ11 - write needs chip select and write strobe low, output enable high
// RQ12 - no command taken during power-up; flash starts in read-array
// RQ13 - reset pin at id level temporarily unprotects sectors
// RQ14 - invalid or out-of-order writes return the flash to read-array
// RQ15 - address taken on the later falling edge of strobe or select
// RQ16 - data taken on the first rising edge of strobe or select
// RQ17 - read-array after power-up and after program or erase ends
// RQ18 - erase-suspend reads: array outside, status inside suspended sectors
// RQ19 - host writes reset after exceeded_limit_flag rises or to leave id mode
// RQ20 - in-system id: maker 00h, device 01h, continuation 03h, protection 02h
// RQ21 - id mode serves any number of reads without a new command
// RQ22 - elevated levels on address line and reset pin are qualifier outputs
package fap_pkg;
  localparam int AW = 18;
  localparam int DW = 16;
  localparam int NSECT = 11;

  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_WRITE = 3'h1,
    OP_RESET = 3'h2,
    OP_AUTOSEL = 3'h3,
    OP_ID = 3'h4,
    OP_PROG = 3'h5,
    OP_UNPROT = 3'h6
  } fap_op_e;

  // register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_WDATA = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_RDATA = 8'h10;
  localparam logic [7:0] OFF_PINS = 8'h14;
  localparam logic [7:0] OFF_PROT = 8'h18;

  // field positions
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_OP_W = 3;
  localparam int CTRL_HV_BIT = 3;
  localparam int CTRL_SECT_LSB = 8;
  localparam int SECT_W = 4;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ERR = 2;
  localparam int ST_REFUSED = 3;
  localparam int ST_EXCEED = 4;
  localparam int PIN_RST_BIT = 0;
  localparam int PIN_UNPROT_BIT = 1;
  localparam int SECT_ADDR_LSB = 12;
  localparam int A6_BIT = 6;
  localparam int A1_BIT = 1;
  localparam int ITEM_W = 2;
  localparam int POLL_BIT = 7;
  localparam int EXCEED_BIT = 5;

  // flash command codes and unlock addresses
  localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_AUTOSEL = 8'h90;
  localparam logic [7:0] CMD_PROG = 8'hA0;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_UNPROT = 8'h60;
  localparam logic [17:0] UNLOCK_A1 = 18'h00555;
  localparam logic [17:0] UNLOCK_A2 = 18'h002AA;
  localparam logic [1:0] ITEM_PROT = 2'h2;
  localparam logic [7:0] PROT_YES = 8'h01;
  localparam logic [2:0] STEP_LAST_AUTOSEL = 3'h2;
  localparam logic [2:0] STEP_LAST_PROG = 3'h3;

  // timing
  localparam int CLK_NS = 4;
  localparam int T_SETUP_NS = 10;
  localparam int T_WE_NS = 35;
  localparam int T_HOLD_NS = 10;
  localparam int T_ACC_NS = 90;
  localparam int T_REC_NS = 20;
  localparam int T_POWERUP_NS = 50000;
  localparam int SYNC_DEPTH = 2;
  localparam logic [15:0] SETUP_CYC = 16'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] WE_CYC = 16'((T_WE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] HOLD_CYC = 16'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] READ_CYC = 16'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_DEPTH);
  localparam logic [15:0] REC_CYC = 16'((T_REC_NS + CLK_NS - 1) / CLK_NS);
  localparam int POWERUP_CYC = (T_POWERUP_NS + CLK_NS - 1) / CLK_NS;
endpackage

// [fap_cyc_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface fap_cyc_if #(
  parameter int AW = fap_pkg::AW,
  parameter int DW = fap_pkg::DW
);
  logic req;
  logic wr;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic busy;
  logic done;
  logic [DW-1:0] rdata;
  modport mst (output req, output wr, output addr, output wdata, input busy, input done, input rdata);
  modport eng (input req, input wr, input addr, input wdata, output busy, output done, output rdata);
endinterface
`default_nettype wire

// [fap_cycle_engine.sv]
`timescale 1ns/1ns
`default_nettype none
module fap_cycle_engine #(
  parameter int AW = fap_pkg::AW,
  parameter int DW = fap_pkg::DW
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // single cycle requests
  fap_cyc_if.eng cyc,
  // flash pins
  output logic flash_ce_b,
  output logic flash_oe_b,
  output logic flash_we_b,
  output logic [AW-1:0] flash_addr,
  input wire logic [DW-1:0] flash_dq_i,
  output logic [DW-1:0] flash_dq_o,
  output logic flash_dq_oe_b
);
  typedef enum logic [5:0] {
    E_IDLE = 6'b000001,
    E_SETUP = 6'b000010,
    E_PULSE = 6'b000100,
    E_HOLD = 6'b001000,
    E_READ = 6'b010000,
    E_REC = 6'b100000
  } fap_eng_st_e;

  typedef struct packed {
    fap_eng_st_e st;
    logic [15:0] cnt;
    logic ce_b;
    logic oe_b;
    logic we_b;
    logic dq_oe_b;
    logic done;
    logic [AW-1:0] addr;
    logic [DW-1:0] dqo;
    logic [DW-1:0] s1;
    logic [DW-1:0] s2;
    logic [DW-1:0] rdata;
  } fap_eng_s;

  localparam fap_eng_s RST = '{st: E_IDLE, ce_b: 1'b1, oe_b: 1'b1, we_b: 1'b1, dq_oe_b: 1'b1, default: '0};

  fap_eng_s q_r;
  fap_eng_s q_nxt;

  always_comb begin
    q_nxt = q_r;
    q_nxt.done = 1'b0;
    // dq comes back asynchronously: two flops before anyone looks
    q_nxt.s1 = flash_dq_i;
    q_nxt.s2 = q_r.s1;
    if (q_r.st != E_IDLE) begin
      q_nxt.cnt = q_r.cnt - 16'h0001;
    end
    case (q_r.st)
      E_IDLE: begin
        if (cyc.req) begin
          q_nxt.addr = cyc.addr;
          q_nxt.dqo = cyc.wdata;
          q_nxt.ce_b = 1'b0;
          if (cyc.wr) begin
            // oe stays high for the whole write [RQ11]
            q_nxt.dq_oe_b = 1'b0;
            q_nxt.cnt = fap_pkg::SETUP_CYC;
            q_nxt.st = E_SETUP;
          end else begin
            q_nxt.oe_b = 1'b0;
            q_nxt.cnt = fap_pkg::READ_CYC;
            q_nxt.st = E_READ;
          end
        end
      end
      E_SETUP: begin
        if (q_r.cnt == 16'h0001) begin
          // we falls after ce, so its edge latches the stable address [RQ15]
          q_nxt.we_b = 1'b0;
          q_nxt.cnt = fap_pkg::WE_CYC;
          q_nxt.st = E_PULSE;
        end
      end
      E_PULSE: begin
        if (q_r.cnt == 16'h0001) begin
          // pulse far wider than a glitch; we rises before ce to latch data [RQ10] [RQ16]
          q_nxt.we_b = 1'b1;
          q_nxt.cnt = fap_pkg::HOLD_CYC;
          q_nxt.st = E_HOLD;
        end
      end
      E_HOLD: begin
        if (q_r.cnt == 16'h0001) begin
          q_nxt.ce_b = 1'b1;
          q_nxt.dq_oe_b = 1'b1;
          q_nxt.cnt = fap_pkg::REC_CYC;
          q_nxt.st = E_REC;
        end
      end
      E_READ: begin
        if (q_r.cnt == 16'h0001) begin
          q_nxt.rdata = q_r.s2;
          q_nxt.oe_b = 1'b1;
          q_nxt.ce_b = 1'b1;
          q_nxt.cnt = fap_pkg::REC_CYC;
          q_nxt.st = E_REC;
        end
      end
      E_REC: begin
        if (q_r.cnt == 16'h0001) begin
          q_nxt.done = 1'b1;
          q_nxt.st = E_IDLE;
        end
      end
      default: q_nxt = RST;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      q_r <= RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign cyc.busy = (q_r.st != E_IDLE);
  assign cyc.done = q_r.done;
  assign cyc.rdata = q_r.rdata;
  assign flash_ce_b = q_r.ce_b;
  assign flash_oe_b = q_r.oe_b;
  assign flash_we_b = q_r.we_b;
  assign flash_addr = q_r.addr;
  assign flash_dq_o = q_r.dqo;
  assign flash_dq_oe_b = q_r.dq_oe_b;
endmodule // fap_cycle_engine
`default_nettype wire

// [fap_host.sv]
`timescale 1ns/1ns
`default_nettype none
module fap_host #(
  parameter int AW = fap_pkg::AW,
  parameter int DW = fap_pkg::DW,
  parameter int NSECT = fap_pkg::NSECT,
  parameter int POWERUP_CYC = fap_pkg::POWERUP_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // flash bus
  output logic flash_ce_b,
  output logic flash_oe_b,
  output logic flash_we_b,
  output logic [AW-1:0] flash_addr,
  input wire logic [DW-1:0] flash_dq_i,
  output logic [DW-1:0] flash_dq_o,
  output logic flash_dq_oe_b,
  // flash reset pin and elevated-level qualifiers
  output logic flash_reset_b,
  output logic id_voltage_address_line,
  output logic reset_id_voltage
);
  typedef enum logic [3:0] {
    S_PWR = 4'b0001,
    S_IDLE = 4'b0010,
    S_ISSUE = 4'b0100,
    S_WAIT = 4'b1000
  } fap_host_st_e;

  typedef struct packed {
    logic last;
    logic wr;
    logic elev;
    logic [AW-1:0] a;
    logic [DW-1:0] d;
  } fap_step_s;

  typedef struct packed {
    fap_host_st_e st;
    logic [15:0] pcnt;
    fap_pkg::fap_op_e op;
    logic hv;
    logic [fap_pkg::SECT_W-1:0] sect;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [2:0] step;
    logic polling;
    logic recover;
    logic req;
    logic cwr;
    logic celev;
    logic [AW-1:0] caddr;
    logic [DW-1:0] cdata;
    logic [DW-1:0] rdata;
    logic done;
    logic err;
    logic refused;
    logic exceed;
    logic pin_rst;
    logic pin_unprot;
    logic [NSECT-1:0] prot;
    logic pend;
    logic [7:0] paddr;
    logic [31:0] hrdata;
  } fap_host_s;

  localparam fap_host_s RST = '{st: S_PWR, pcnt: 16'(POWERUP_CYC), op: fap_pkg::OP_READ, pin_rst: 1'b1,
                                default: '0};

  // one cycle of a sequence; unlock prefix keeps lone writes off the array
  function automatic fap_step_s fap_step(input fap_pkg::fap_op_e op, input logic [2:0] idx,
                                         input logic [AW-1:0] a, input logic [DW-1:0] d, input logic hv);
    fap_step_s s;
    logic [AW-1:0] ida;
    ida = '0;
    ida[AW-1:fap_pkg::SECT_ADDR_LSB] = a[AW-1:fap_pkg::SECT_ADDR_LSB];
    ida[fap_pkg::ITEM_W-1:0] = a[fap_pkg::ITEM_W-1:0];
    s.last = 1'b1;
    s.wr = 1'b1;
    s.elev = 1'b0;
    s.a = a;
    s.d = d;
    case (op)
      fap_pkg::OP_READ: s.wr = 1'b0;
      fap_pkg::OP_RESET: s.d = DW'(fap_pkg::CMD_RESET); // [RQ19]
      fap_pkg::OP_AUTOSEL, fap_pkg::OP_PROG: begin // [RQ5] [RQ9]
        s.last = (op == fap_pkg::OP_AUTOSEL) ? (idx == fap_pkg::STEP_LAST_AUTOSEL) : (idx == fap_pkg::STEP_LAST_PROG);
        case (idx)
          3'h0: begin
            s.a = AW'(fap_pkg::UNLOCK_A1);
            s.d = DW'(fap_pkg::CMD_UNLOCK1);
          end
          3'h1: begin
            s.a = AW'(fap_pkg::UNLOCK_A2);
            s.d = DW'(fap_pkg::CMD_UNLOCK2);
          end
          3'h2: begin
            s.a = AW'(fap_pkg::UNLOCK_A1);
            s.d = (op == fap_pkg::OP_AUTOSEL) ? DW'(fap_pkg::CMD_AUTOSEL) : DW'(fap_pkg::CMD_PROG);
          end
          default: ;
        endcase
      end
      fap_pkg::OP_ID: begin
        // A6 low, item on A1/A0, sector on top bits [RQ2] [RQ4] [RQ20] [RQ21]
        s.wr = 1'b0;
        s.a = ida;
        s.elev = hv; // [RQ3] [RQ22]
      end
      fap_pkg::OP_UNPROT: begin
        s.a = ida;
        s.a[fap_pkg::A6_BIT] = 1'b1;
        s.a[fap_pkg::A1_BIT] = 1'b1;
        s.d = DW'(fap_pkg::CMD_UNPROT);
        s.elev = hv;
      end
      default: ;
    endcase
    return s;
  endfunction

  fap_host_s q_r;
  fap_host_s q_nxt;
  fap_step_s stp;
  logic [31:0] status;
  logic start_ok;

  fap_cyc_if #(.AW(AW), .DW(DW)) cyc ();

  fap_cycle_engine #(.AW(AW), .DW(DW)) u_eng (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .cyc(cyc),
    .flash_ce_b(flash_ce_b),
    .flash_oe_b(flash_oe_b),
    .flash_we_b(flash_we_b),
    .flash_addr(flash_addr),
    .flash_dq_i(flash_dq_i),
    .flash_dq_o(flash_dq_o),
    .flash_dq_oe_b(flash_dq_oe_b)
  );

  always_comb begin
    status = '0;
    status[fap_pkg::ST_BUSY] = (q_r.st != S_IDLE);
    status[fap_pkg::ST_DONE] = q_r.done;
    status[fap_pkg::ST_ERR] = q_r.err;
    status[fap_pkg::ST_REFUSED] = q_r.refused;
    status[fap_pkg::ST_EXCEED] = q_r.exceed;
    stp = fap_step(q_r.op, q_r.step, q_r.addr, q_r.wdata, q_r.hv);
    // unprotect only once every sector is known protected [RQ7]
    start_ok = (fap_pkg::fap_op_e'(hwdata[fap_pkg::CTRL_OP_LSB +: fap_pkg::CTRL_OP_W]) != fap_pkg::OP_UNPROT)
               || (&q_r.prot);
  end

  always_comb begin
    q_nxt = q_r;
    q_nxt.req = 1'b0;
    // ahb address phase: word accesses only
    if (hsel && hready && htrans[1] && (hsize == 3'b010)) begin
      q_nxt.pend = hwrite;
      q_nxt.paddr = haddr[7:0];
      case (haddr[7:0])
        fap_pkg::OFF_CTRL: q_nxt.hrdata = {20'h00000, q_r.sect, 4'h0, q_r.hv, q_r.op};
        fap_pkg::OFF_ADDR: q_nxt.hrdata = {{(32 - AW){1'b0}}, q_r.addr};
        fap_pkg::OFF_WDATA: q_nxt.hrdata = {{(32 - DW){1'b0}}, q_r.wdata};
        fap_pkg::OFF_STATUS: q_nxt.hrdata = status;
        fap_pkg::OFF_RDATA: q_nxt.hrdata = {{(32 - DW){1'b0}}, q_r.rdata};
        fap_pkg::OFF_PINS: q_nxt.hrdata = {30'h00000000, q_r.pin_unprot, q_r.pin_rst};
        fap_pkg::OFF_PROT: q_nxt.hrdata = {{(32 - NSECT){1'b0}}, q_r.prot};
        default: q_nxt.hrdata = '0;
      endcase
    end else begin
      q_nxt.pend = 1'b0;
    end
    // ahb data phase of a write
    if (q_r.pend) begin
      case (q_r.paddr)
        fap_pkg::OFF_CTRL: begin
          if (q_r.st == S_IDLE && start_ok) begin
            q_nxt.op = fap_pkg::fap_op_e'(hwdata[fap_pkg::CTRL_OP_LSB +: fap_pkg::CTRL_OP_W]);
            q_nxt.hv = hwdata[fap_pkg::CTRL_HV_BIT];
            q_nxt.sect = hwdata[fap_pkg::CTRL_SECT_LSB +: fap_pkg::SECT_W];
            q_nxt.step = 3'h0;
            q_nxt.polling = 1'b0;
            q_nxt.recover = 1'b0;
            q_nxt.done = 1'b0;
            q_nxt.err = 1'b0;
            q_nxt.refused = 1'b0;
            q_nxt.exceed = 1'b0;
            q_nxt.st = S_ISSUE;
          end else begin
            q_nxt.refused = 1'b1;
          end
        end
        fap_pkg::OFF_ADDR: q_nxt.addr = hwdata[AW-1:0];
        fap_pkg::OFF_WDATA: q_nxt.wdata = hwdata[DW-1:0];
        fap_pkg::OFF_PINS: begin
          q_nxt.pin_rst = hwdata[fap_pkg::PIN_RST_BIT];
          q_nxt.pin_unprot = hwdata[fap_pkg::PIN_UNPROT_BIT]; // [RQ13] [RQ22]
        end
        fap_pkg::OFF_PROT: q_nxt.prot = hwdata[NSECT-1:0];
        default: ;
      endcase
    end
    // sequencer; its updates come last so hardware wins over software
    case (q_r.st)
      S_PWR: begin
        // flash ignores commands while powering up; start idle on nothing [RQ12] [RQ17]
        q_nxt.pcnt = q_r.pcnt - 16'h0001;
        if (q_r.pcnt == 16'h0000) begin
          q_nxt.st = S_IDLE;
        end
      end
      S_IDLE: ;
      S_ISSUE: begin
        q_nxt.req = 1'b1;
        q_nxt.st = S_WAIT;
        if (q_r.recover) begin
          q_nxt.cwr = 1'b1;
          q_nxt.celev = 1'b0;
          q_nxt.caddr = q_r.addr;
          q_nxt.cdata = DW'(fap_pkg::CMD_RESET); // [RQ19]
        end else if (q_r.polling) begin
          q_nxt.cwr = 1'b0;
          q_nxt.celev = 1'b0;
          q_nxt.caddr = q_r.addr;
        end else begin
          q_nxt.cwr = stp.wr;
          q_nxt.celev = stp.elev;
          q_nxt.caddr = stp.a;
          q_nxt.cdata = stp.d;
        end
      end
      S_WAIT: begin
        if (cyc.done) begin
          q_nxt.st = S_IDLE;
          if (q_r.recover) begin
            q_nxt.err = 1'b1;
            q_nxt.done = 1'b1;
          end else if (q_r.polling) begin
            q_nxt.rdata = cyc.rdata;
            if (cyc.rdata[fap_pkg::POLL_BIT] == q_r.wdata[fap_pkg::POLL_BIT]) begin
              q_nxt.done = 1'b1;
            end else if (cyc.rdata[fap_pkg::EXCEED_BIT]) begin
              // exceeded_limit_flag: only a reset command brings read-array back [RQ19]
              q_nxt.exceed = 1'b1;
              q_nxt.recover = 1'b1;
              q_nxt.st = S_ISSUE;
            end else begin
              q_nxt.st = S_ISSUE;
            end
          end else if (stp.last) begin
            q_nxt.rdata = cyc.rdata;
            if (q_r.op == fap_pkg::OP_PROG) begin
              q_nxt.polling = 1'b1;
              q_nxt.st = S_ISSUE;
            end else begin
              q_nxt.done = 1'b1;
            end
            if (q_r.op == fap_pkg::OP_ID && q_r.addr[fap_pkg::ITEM_W-1:0] == fap_pkg::ITEM_PROT
                && 32'(q_r.sect) < NSECT) begin
              q_nxt.prot[q_r.sect] = (cyc.rdata[7:0] == fap_pkg::PROT_YES); // [RQ4] [RQ1]
            end
          end else begin
            q_nxt.step = q_r.step + 3'h1;
            q_nxt.st = S_ISSUE;
          end
        end
      end
      default: q_nxt = RST;
    endcase
    if (q_nxt.st == S_IDLE) begin
      q_nxt.celev = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      q_r <= RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign cyc.req = q_r.req;
  assign cyc.wr = q_r.cwr;
  assign cyc.addr = q_r.caddr;
  assign cyc.wdata = q_r.cdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q_r.hrdata;
  assign flash_reset_b = q_r.pin_rst;
  assign id_voltage_address_line = q_r.celev;
  assign reset_id_voltage = q_r.pin_unprot;
endmodule // fap_host
`default_nettype wire

// [fap_host_monitor.sv]
`timescale 1ns/1ns
`default_nettype none
module fap_host_monitor (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // watched outputs
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic flash_ce_b,
  input wire logic flash_oe_b,
  input wire logic flash_we_b,
  input wire logic [fap_pkg::AW-1:0] flash_addr,
  input wire logic [fap_pkg::DW-1:0] flash_dq_o,
  input wire logic flash_dq_oe_b,
  input wire logic id_voltage_address_line
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not okay");
  a_write_qual: assert property (!flash_we_b |-> !flash_ce_b && flash_oe_b) else $error("strobe without select");
  a_no_contention: assert property (!flash_dq_oe_b |-> flash_oe_b) else $error("data driven in read");
  a_strobe_width: assert property (
    $fell(flash_we_b) |-> !flash_we_b [*8] ##1 !flash_we_b ##1 flash_we_b) else $error("strobe width wrong");
  a_addr_setup: assert property (
    $fell(flash_we_b) |-> $past(!flash_ce_b, 2) && $stable(flash_addr)) else $error("address not set up");
  a_write_hold: assert property (
    !flash_we_b |-> $stable(flash_addr) && $stable(flash_dq_o)) else $error("write cycle moved");
  a_data_hold: assert property (
    $rose(flash_we_b) |-> (!flash_ce_b && !flash_dq_oe_b && $stable(flash_dq_o)) [*3] ##1 flash_ce_b)
    else $error("data hold wrong");
  a_read_time: assert property ($fell(flash_oe_b) |-> !flash_ce_b ##24 !flash_oe_b ##1 flash_oe_b)
    else $error("read length wrong");
  a_recovery: assert property ($rose(flash_ce_b) |-> flash_ce_b [*5]) else $error("recovery too short");
  a_id_a6_low: assert property (
    id_voltage_address_line && !flash_oe_b |-> !flash_addr[6]) else $error("id read with a6 high");
endmodule // fap_host_monitor
bind fap_host fap_host_monitor i_mon (.clk_sys(clk_sys), .rst_b(rst_b), .hreadyout(hreadyout), .hresp(hresp),
  .flash_ce_b(flash_ce_b), .flash_oe_b(flash_oe_b), .flash_we_b(flash_we_b), .flash_addr(flash_addr),
  .flash_dq_o(flash_dq_o), .flash_dq_oe_b(flash_dq_oe_b), .id_voltage_address_line(id_voltage_address_line));
`default_nettype wire

// [fap_flash_model.sv]
`timescale 1ns/1ns
`default_nettype none
module fap_flash_model #(
  parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary
  parameter logic [7:0] DEV_ID = 8'hC3, // arbitrary
  parameter logic [7:0] CONT_ID = 8'h1E, // arbitrary
  parameter int PWR_NS = 150
) (
  // controls and data from the host
  input wire logic ce_b,
  input wire logic oe_b,
  input wire logic we_b,
  input wire logic [17:0] addr,
  input wire logic [15:0] dq_o,
  input wire logic dq_oe_b,
  input wire logic reset_b,
  // elevated level qualifiers
  input wire logic id_hv,
  input wire logic rst_hv,
  // resolved data bus
  output logic [15:0] dq
);
  logic [15:0] mem [logic [17:0]];
  logic [10:0] prot = 11'h000;
  logic id_mode = 1'b0;
  logic fail_r = 1'b0;
  logic fd7 = 1'b0;
  logic [17:0] wa = 18'h00000;
  logic [15:0] last_v = 16'h0000;
  int step = 0;
  realtime t_lo = 0;
  wire wr_act = !ce_b && !we_b && oe_b && reset_b;
  wire rd_act = !ce_b && !oe_b && reset_b && dq_oe_b;
  function automatic int sect(input logic [17:0] a);
    if (a[17:15] != 3'h7) return int'(a[17:15]);
    if (!a[14]) return 7;
    if (!a[13]) return a[12] ? 9 : 8;
    return 10;
  endfunction
  function automatic logic [15:0] rd_val(input logic [17:0] a);
    logic [7:0] c;
    case (a[1:0])
      2'h0: c = MAKER_ID;
      2'h1: c = DEV_ID;
      2'h3: c = CONT_ID;
      default: c = prot[sect(a)] ? 8'h01 : 8'h00;
    endcase
    if (fail_r) return {8'h00, ~fd7, 7'h20};
    if ((id_hv && !a[6]) || id_mode) return {8'h00, c};
    // no sector is ever erase-suspended here, so every read outside id mode, elevated id reads with A6 low and failed-program status gets array data
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction
  task automatic cmd(input logic [17:0] a, input logic [15:0] d);
    if (d[7:0] == 8'hF0) begin
      step = 0;
      id_mode = 1'b0;
      fail_r = 1'b0;
    end else if (step == 0 && a == 18'h00555 && d[7:0] == 8'hAA) step = 1;
    else if (step == 1 && a == 18'h002AA && d[7:0] == 8'h55) step = 2;
    else if (step == 2 && a == 18'h00555 && d[7:0] == 8'h90) begin
      step = 0;
      id_mode = 1'b1;
    end else if (step == 2 && a == 18'h00555 && d[7:0] == 8'hA0) step = 3;
    else if (step == 3) begin
      step = 0;
      // a program to an unprotected sector finishes at once, so the array is back straight away
      if (prot[sect(a)] && !rst_hv) begin
        fail_r = 1'b1;
        fd7 = d[7];
      end else mem[a] = d;
    end else begin
      step = 0;
      id_mode = 1'b0;
    end
  endtask
  always @(posedge wr_act) begin
    wa = addr;
    t_lo = $realtime;
  end
  always @(negedge wr_act) begin
    if ($realtime - t_lo >= 5 && $realtime >= PWR_NS) cmd(wa, dq_o);
  end
  always @(negedge rd_act) last_v = rd_val(addr);
  // released bus shows the inverse of the last value, never a stale copy
  always_comb begin
    if (!dq_oe_b) dq = dq_o;
    else if (rd_act) dq = rd_val(addr);
    else dq = ~last_v;
  end
endmodule // fap_flash_model
`default_nettype wire

// [fap_host_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module fap_host_tb_top;
  localparam logic [7:0] MAKER_ID = 8'h5A; // arbitrary
  localparam logic [7:0] DEV_ID = 8'hC3; // arbitrary
  localparam logic [7:0] CONT_ID = 8'h1E; // arbitrary
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] r, st, rdat;
  logic [31:0] seed = 32'hE9FA;
  logic [15:0] w;
  wire hreadyout, hresp, ce_b, oe_b, we_b, dq_oe_b, reset_b, id_hv, rst_hv;
  wire [31:0] hrdata;
  wire [17:0] faddr;
  wire [15:0] dq_o, dq;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  initial forever #2 clk_sys = ~clk_sys;
  fap_host #(.POWERUP_CYC(40)) i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .flash_ce_b(ce_b), .flash_oe_b(oe_b), .flash_we_b(we_b), .flash_addr(faddr),
    .flash_dq_i(dq), .flash_dq_o(dq_o), .flash_dq_oe_b(dq_oe_b), .flash_reset_b(reset_b),
    .id_voltage_address_line(id_hv), .reset_id_voltage(rst_hv));
  fap_flash_model #(.MAKER_ID(MAKER_ID), .DEV_ID(DEV_ID), .CONT_ID(CONT_ID)) i_flash (.ce_b(ce_b), .oe_b(oe_b),
    .we_b(we_b), .addr(faddr), .dq_o(dq_o), .dq_oe_b(dq_oe_b), .reset_b(reset_b), .id_hv(id_hv), .rst_hv(rst_hv),
    .dq(dq));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [31:0] exp_id(input logic [1:0] item, input logic p);
    case (item)
      2'h0: return {24'h0, MAKER_ID};
      2'h1: return {24'h0, DEV_ID};
      2'h3: return {24'h0, CONT_ID};
      default: return p ? 32'h1 : 32'h0;
    endcase
  endfunction
  function automatic logic [31:0] ctl(input fap_pkg::fap_op_e op, input logic hv = 1'b0, input logic [3:0] s = 4'h0);
    return (32'(op) << fap_pkg::CTRL_OP_LSB) | (32'(hv) << fap_pkg::CTRL_HV_BIT) | (32'(s) << fap_pkg::CTRL_SECT_LSB);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic idle();
    int n = 0;
    do begin
      xfer(1'b0, fap_pkg::OFF_STATUS, 32'h0, st);
      n++;
    end while (st[fap_pkg::ST_BUSY] !== 1'b0 && n < 3000);
  endtask
  task automatic run(input logic [31:0] c, input logic [17:0] a, input logic [15:0] d = 16'h0);
    xfer(1'b1, fap_pkg::OFF_ADDR, {14'h0, a}, r);
    xfer(1'b1, fap_pkg::OFF_WDATA, {16'h0, d}, r);
    xfer(1'b1, fap_pkg::OFF_CTRL, c, r);
    idle();
    xfer(1'b0, fap_pkg::OFF_RDATA, 32'h0, rdat);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      complete_run();
    end
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    xfer(1'b1, fap_pkg::OFF_CTRL, 32'h0, r);
    xfer(1'b0, fap_pkg::OFF_STATUS, 32'h0, r);
    check(r & 32'h9, 32'h9);
    xfer(1'b0, fap_pkg::OFF_PINS, 32'h0, r);
    check(r, 32'h1);
    xfer(1'b0, fap_pkg::OFF_PROT, 32'h0, r);
    check(r, 32'h0);
    xfer(1'b0, 8'h1C, 32'h0, r);
    check(r, 32'h0);
    idle();
    run(ctl(fap_pkg::OP_AUTOSEL), 18'h0);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      run(ctl(fap_pkg::OP_ID), seed[17:0]);
      check(rdat, exp_id(seed[1:0], 1'b0));
    end
    run(ctl(fap_pkg::OP_RESET), 18'h0);
    run(ctl(fap_pkg::OP_ID), 18'h28000);
    check(rdat, 32'hFFFF);
    i_flash.prot[5] = 1'b1;
    for (int i = 0; i < 4; i++) begin
      run(ctl(fap_pkg::OP_ID, 1'b1, 4'h5), 18'h28000 | 18'(i));
      check(rdat, exp_id(2'(i), 1'b1));
    end
    xfer(1'b0, fap_pkg::OFF_PROT, 32'h0, r);
    check(r, 32'h20);
    run(ctl(fap_pkg::OP_UNPROT, 1'b1), 18'h28000);
    check(st & 32'h8, 32'h8);
    seed = lfsr(seed);
    w = seed[15:0];
    run(ctl(fap_pkg::OP_PROG), 18'h10000, w);
    check(st & 32'h7, 32'h2);
    run(ctl(fap_pkg::OP_READ), 18'h10000);
    check(rdat, {16'h0, w});
    // data bit 7 low: failed status never matches it
    run(ctl(fap_pkg::OP_PROG), 18'h28010, 16'h1234);
    check(st & 32'h14, 32'h14);
    run(ctl(fap_pkg::OP_READ), 18'h28010);
    check(rdat, 32'hFFFF);
    xfer(1'b1, fap_pkg::OFF_PINS, 32'h3, r);
    run(ctl(fap_pkg::OP_PROG), 18'h28010, 16'h1234);
    run(ctl(fap_pkg::OP_READ), 18'h28010);
    check(rdat, 32'h1234);
    xfer(1'b1, fap_pkg::OFF_PINS, 32'h1, r);
    run(ctl(fap_pkg::OP_PROG), 18'h28020, 16'h5600);
    check(st & 32'h14, 32'h14);
    run(ctl(fap_pkg::OP_AUTOSEL), 18'h0);
    run(ctl(fap_pkg::OP_WRITE), 18'h10000, 16'h0012);
    run(ctl(fap_pkg::OP_READ), 18'h10000);
    check(rdat, {16'h0, w});
    complete_run();
  end
endmodule // fap_host_tb_top
`default_nettype wire
